// ---- logic/scg2_gating.v ----
// Bank-two peripheral clock gating control with AXI4-Lite registers
`timescale 1ns/100ps
`default_nettype none
`include "scg2_map.vh"
module scg2_gating (
    // Clock, reset, enable
    input wire mclk_i,
    input wire rst_i,
    input wire ce_i,
    // Power state from the power manager
    input wire [1:0] power_mode_i,
    // Peripheral access probes, one bit per gated unit
    input wire [8:0] periph_rd_i,
    input wire [8:0] periph_wr_i,
    // AXI4-Lite write address
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [11:0] s_axi_awaddr,
    // AXI4-Lite write data
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    output reg [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    input wire [11:0] s_axi_araddr,
    // AXI4-Lite read data
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    // Unit clock enables and faults
    output wire [8:0] unit_clk_en_o,
    output reg [8:0] unit_fault_o,
    output wire irq_o
);
    // ***************************************************************
    // Registers
    // ***************************************************************
    reg [31:0] run_gate_reg_b_q;
    reg [31:0] sleep_gate_reg_b_q;
    reg [31:0] deep_sleep_gate_reg_b_q;
    reg auto_gating_select_q;
    reg [1:0] irq_stat_q;
    reg [1:0] irq_mask_q;
    reg aw_held_q;
    reg [11:0] aw_addr_q;
    reg w_held_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    wire [31:0] run_wide;
    wire [31:0] sleep_wide;
    wire [31:0] dsleep_wide;
    wire [8:0] run_vec;
    wire [8:0] sleep_vec;
    wire [8:0] dsleep_vec;
    wire [8:0] fault_rd;
    wire [8:0] fault_wr;
    wire [8:0] fault_any;
    wire do_write;
    wire [31:0] wmask;
    wire [31:0] wmerge;
    genvar gi;

    // ***************************************************************
    // Unit enable vectors: ports A..G, then MAC, then PHY
    // ***************************************************************
    assign run_wide = run_gate_reg_b_q;
    assign sleep_wide = sleep_gate_reg_b_q;
    assign dsleep_wide = deep_sleep_gate_reg_b_q;
    assign run_vec = {run_wide[`SCG2_BIT_PHY], run_wide[`SCG2_BIT_MAC], run_wide[6:0]};
    assign sleep_vec = {sleep_wide[`SCG2_BIT_PHY], sleep_wide[`SCG2_BIT_MAC], sleep_wide[6:0]};
    assign dsleep_vec = {dsleep_wide[`SCG2_BIT_PHY], dsleep_wide[`SCG2_BIT_MAC],
        dsleep_wide[6:0]};

    generate
        for (gi = 0; gi < `SCG2_UNITS; gi = gi + 1) begin : g_unit
            scg2_unit_gate u_gate (
                .mode_i(power_mode_i),
                .auto_i(auto_gating_select_q),
                .run_en_i(run_vec[gi]),
                .sleep_en_i(sleep_vec[gi]),
                .dsleep_en_i(dsleep_vec[gi]),
                .access_i(periph_rd_i[gi] | periph_wr_i[gi]),
                .clk_en_o(unit_clk_en_o[gi]),
                .fault_o(fault_any[gi])
            );
        end
    endgenerate
    // split faults by direction for the event bits
    assign fault_rd = periph_rd_i & ~unit_clk_en_o;
    assign fault_wr = periph_wr_i & ~unit_clk_en_o;

    // fault answer registered toward the peripheral bus
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            unit_fault_o <= 9'h000;
        end else if (ce_i) begin
            unit_fault_o <= fault_any;
        end
    end

    // ***************************************************************
    // AXI4-Lite write path
    // ***************************************************************
    // Address and data are latched independently, either order
    assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;
    assign do_write = aw_held_q & w_held_q & ~s_axi_bvalid;
    assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

    // Capture of the write channels
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 12'h000;
            w_held_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else if (ce_i) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (do_write) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // Register update, interrupt events, write response
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            run_gate_reg_b_q <= `SCG2_GATE_RESET;
            sleep_gate_reg_b_q <= `SCG2_GATE_RESET;
            deep_sleep_gate_reg_b_q <= `SCG2_GATE_RESET;
            auto_gating_select_q <= 1'b0;
            irq_stat_q <= 2'h0;
            irq_mask_q <= 2'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SCG2_RESP_OKAY;
        end else if (ce_i) begin
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `SCG2_RESP_OKAY;
                case (aw_addr_q)
                    // three banks at their own offsets
                    // run register holds ports D..A only
                    `SCG2_RUN_GATE_OFS: begin
                        run_gate_reg_b_q <= ((run_gate_reg_b_q & ~wmask) |
                            (w_data_q & wmask)) & `SCG2_RUN_MASK;
                    end
                    `SCG2_SLEEP_GATE_OFS: begin
                        sleep_gate_reg_b_q <= ((sleep_gate_reg_b_q & ~wmask) |
                            (w_data_q & wmask)) & `SCG2_GATE_MASK;
                    end
                    `SCG2_DSLEEP_GATE_OFS: begin
                        deep_sleep_gate_reg_b_q <= ((deep_sleep_gate_reg_b_q & ~wmask) |
                            (w_data_q & wmask)) & `SCG2_GATE_MASK;
                    end
                    `SCG2_CTRL_OFS: begin
                        if (w_strb_q[0]) begin
                            auto_gating_select_q <= w_data_q[`SCG2_CTRL_AUTO_BIT];
                        end
                    end
                    `SCG2_IRQ_MASK_OFS: begin
                        if (w_strb_q[0]) begin
                            irq_mask_q <= w_data_q[1:0];
                        end
                    end
                    `SCG2_STATUS_OFS, `SCG2_IRQ_STAT_OFS: begin
                        s_axi_bresp <= `SCG2_RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= `SCG2_RESP_SLVERR;
                    end
                endcase
            end
            // Write-one-to-clear, a new event in the same cycle wins
            irq_stat_q <= (irq_stat_q & ~((do_write && aw_addr_q == `SCG2_IRQ_STAT_OFS &&
                w_strb_q[0]) ? w_data_q[1:0] : 2'h0)) | {|fault_wr, |fault_rd};
        end
    end

    // Level interrupt while any unmasked event is pending
    assign irq_o = |(irq_stat_q & irq_mask_q);

    // ***************************************************************
    // AXI4-Lite read path
    // ***************************************************************
    assign s_axi_arready = ~s_axi_rvalid;

    // One-cycle read answer after the address is taken
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SCG2_RESP_OKAY;
        end else if (ce_i) begin
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `SCG2_RESP_OKAY;
                case (s_axi_araddr)
                    `SCG2_RUN_GATE_OFS: begin
                        s_axi_rdata <= run_gate_reg_b_q;
                    end
                    `SCG2_SLEEP_GATE_OFS: begin
                        s_axi_rdata <= sleep_gate_reg_b_q;
                    end
                    `SCG2_DSLEEP_GATE_OFS: begin
                        s_axi_rdata <= deep_sleep_gate_reg_b_q;
                    end
                    `SCG2_CTRL_OFS: begin
                        s_axi_rdata <= {31'h0, auto_gating_select_q};
                    end
                    // Live unit enables in register layout
                    `SCG2_STATUS_OFS: begin
                        s_axi_rdata <= {1'b0, unit_clk_en_o[8], 1'b0, unit_clk_en_o[7],
                            21'h0, unit_clk_en_o[6:0]};
                    end
                    `SCG2_IRQ_STAT_OFS: begin
                        s_axi_rdata <= {30'h0, irq_stat_q};
                    end
                    `SCG2_IRQ_MASK_OFS: begin
                        s_axi_rdata <= {30'h0, irq_mask_q};
                    end
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `SCG2_RESP_SLVERR;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ---- logic/scg2_map.vh ----
// Register map and field constants for the bank-two sleep clock gating block
`ifndef SCG2_MAP_VH
`define SCG2_MAP_VH
// ***************************************************************
// Register byte offsets
// ***************************************************************
`define SCG2_RUN_GATE_OFS 12'h108
`define SCG2_SLEEP_GATE_OFS 12'h118
`define SCG2_DSLEEP_GATE_OFS 12'h128
`define SCG2_CTRL_OFS 12'h130
`define SCG2_STATUS_OFS 12'h134
`define SCG2_IRQ_STAT_OFS 12'h138
`define SCG2_IRQ_MASK_OFS 12'h13c
// ***************************************************************
// Field layout and reset values
// ***************************************************************
`define SCG2_GATE_MASK 32'h5000007f
`define SCG2_GATE_RESET 32'h00000000
`define SCG2_BIT_PHY 30
`define SCG2_BIT_MAC 28
`define SCG2_RUN_MASK 32'h0000000f
`define SCG2_CTRL_AUTO_BIT 0
`define SCG2_IRQ_MASK_BITS 32'h00000003
`define SCG2_IRQ_RD_FAULT 0
`define SCG2_IRQ_WR_FAULT 1
`define SCG2_UNITS 9
// AXI response codes
`define SCG2_RESP_OKAY 2'h0
`define SCG2_RESP_SLVERR 2'h2
// Power modes
`define SCG2_MODE_RUN 2'h0
`define SCG2_MODE_SLEEP 2'h1
`define SCG2_MODE_DSLEEP 2'h2
`endif

// ---- logic/scg2_unit_gate.v ----
// One per-unit clock enable selector with access fault decision
`timescale 1ns/100ps
`default_nettype none
`include "scg2_map.vh"
module scg2_unit_gate (
    // Gate sources
    input wire [1:0] mode_i,
    input wire auto_i,
    input wire run_en_i,
    input wire sleep_en_i,
    input wire dsleep_en_i,
    // Peripheral access probe
    input wire access_i,
    // Results
    output reg clk_en_o,
    output wire fault_o
);
    // Sleep banks apply only under automatic gating, run bank otherwise
    // run bank governs without auto
    always @* begin
        clk_en_o = run_en_i;
        if (auto_i && mode_i == `SCG2_MODE_SLEEP) begin
            clk_en_o = sleep_en_i;
        end else if (auto_i && mode_i == `SCG2_MODE_DSLEEP) begin
            clk_en_o = dsleep_en_i;
        end
    end
    // An access to an unclocked unit is faulted
    assign fault_o = access_i & ~clk_en_o;
endmodule
`default_nettype wire

// ---- sim/scg2_gating_props.sv ----
// Bus handshake and gating checks for the bank-two clock gating block
`timescale 1ns/100ps
`default_nettype none
module scg2_props (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Unit side
    input wire logic [1:0] power_mode_i,
    input wire logic [8:0] periph_rd_i,
    input wire logic [8:0] periph_wr_i,
    input wire logic [8:0] unit_clk_en_o,
    input wire logic [8:0] unit_fault_o,
    // Bus side
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // Fault answers any probe of an unclocked unit
    property p_fault;
        ce_i |=> unit_fault_o == $past((periph_rd_i | periph_wr_i) & ~unit_clk_en_o);
    endproperty
    a_fault: assert property (p_fault) else $error("fault mismatch");
    // Run mode clocks only the four low ports
    property p_run_upper;
        (power_mode_i == 2'h0 || power_mode_i == 2'h3) |-> unit_clk_en_o[8:4] == 5'h00;
    endproperty
    a_run_upper: assert property (p_run_upper) else $error("run upper clocked");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
    property p_rans;
        ce_i && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    property p_bans;
        ce_i && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_bans: assert property (p_bans) else $error("write answer late");
    property p_arref;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_arref: assert property (p_arref) else $error("read taken while busy");
    property p_awref;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_awref: assert property (p_awref) else $error("write taken while busy");
endmodule
bind scg2_gating scg2_props u_scg2_props (.mclk_i, .rst_i, .ce_i, .power_mode_i,
    .periph_rd_i, .periph_wr_i, .unit_clk_en_o, .unit_fault_o, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata);
`default_nettype wire

// ---- sim/scg2_gating_bench.sv ----
// Register and gating tests for the bank-two clock gating block
`timescale 1ns/100ps
`default_nettype none
`include "scg2_map.vh"
module scg2_gating_bench;
    logic mclk_i = 0, rst_i = 1, ce_i = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [1:0] power_mode_i = 0, resp;
    logic [8:0] periph_rd_i = 0, periph_wr_i = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, rd_q;
    logic [3:0] s_axi_wstrb = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_o;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [8:0] unit_clk_en_o, unit_fault_o;
    integer err_count = 0, check_count = 0, cyc = 0;
    scg2_gating u_scg2_gating (.mclk_i, .rst_i, .ce_i, .power_mode_i, .periph_rd_i,
        .periph_wr_i, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .unit_clk_en_o, .unit_fault_o, .irq_o);
    initial forever #5 mclk_i = ~mclk_i;
    task close_out;
        begin
            $display("checks %0d mismatches %0d", check_count, err_count);
            if (err_count == 0 && check_count > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask
    // Hang guard, far above the hundred or so cycles needed
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count = err_count + 1;
            close_out;
        end
    end
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        begin
            check_count++;
            if (seen !== exp) begin
                err_count++;
                $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // Readiness sampled mid-cycle, acted on at the next rising edge
    task wc(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_t, w_t, b_t;
        begin
            @(posedge mclk_i);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_wstrb <= 4'hf;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            b_t = 0;
            while (!b_t) begin
                @(negedge mclk_i);
                aw_t = s_axi_awvalid && s_axi_awready;
                w_t = s_axi_wvalid && s_axi_wready;
                b_t = s_axi_bvalid;
                resp = s_axi_bresp;
                @(posedge mclk_i);
                if (aw_t) s_axi_awvalid <= 1'b0;
                if (w_t) s_axi_wvalid <= 1'b0;
            end
            s_axi_bready <= 1'b0;
            check("bresp", resp, er);
        end
    endtask
    task rc(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic ar_t, r_t;
        begin
            @(posedge mclk_i);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            r_t = 0;
            while (!r_t) begin
                @(negedge mclk_i);
                ar_t = s_axi_arvalid && s_axi_arready;
                r_t = s_axi_rvalid;
                rd_q = s_axi_rdata;
                resp = s_axi_rresp;
                @(posedge mclk_i);
                if (ar_t) s_axi_arvalid <= 1'b0;
            end
            s_axi_rready <= 1'b0;
            check("rdata", rd_q, exp);
            check("rresp", resp, er);
        end
    endtask
    task mode(input logic [1:0] m, input logic [8:0] exp);
        begin
            @(posedge mclk_i);
            power_mode_i <= m;
            @(negedge mclk_i);
            check("clk_en", unit_clk_en_o, exp);
        end
    endtask
    // Probe held over two edges, fault looked at after the first
    task probe(input logic [8:0] r, input logic [8:0] w, input logic [8:0] exp);
        begin
            @(posedge mclk_i);
            periph_rd_i <= r;
            periph_wr_i <= w;
            @(posedge mclk_i);
            @(negedge mclk_i);
            check("fault", unit_fault_o, exp);
            @(posedge mclk_i);
            periph_rd_i <= 9'h000;
            periph_wr_i <= 9'h000;
        end
    endtask
    // ****
    // Main sequence
    // ****
    initial begin
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        check("clk_en", unit_clk_en_o, 32'h0);
        rc(`SCG2_RUN_GATE_OFS, 32'h0, `SCG2_RESP_OKAY);
        rc(`SCG2_SLEEP_GATE_OFS, 32'h0, `SCG2_RESP_OKAY);
        rc(`SCG2_DSLEEP_GATE_OFS, 32'h0, `SCG2_RESP_OKAY);
        wc(`SCG2_RUN_GATE_OFS, 32'hffffffff, `SCG2_RESP_OKAY);
        rc(`SCG2_RUN_GATE_OFS, 32'h0000000f, `SCG2_RESP_OKAY);
        wc(`SCG2_SLEEP_GATE_OFS, 32'hffffffff, `SCG2_RESP_OKAY);
        rc(`SCG2_SLEEP_GATE_OFS, 32'h5000007f, `SCG2_RESP_OKAY);
        wc(`SCG2_DSLEEP_GATE_OFS, 32'hffffffff, `SCG2_RESP_OKAY);
        rc(`SCG2_DSLEEP_GATE_OFS, 32'h5000007f, `SCG2_RESP_OKAY);
        wc(12'h200, 32'hffffffff, `SCG2_RESP_SLVERR);
        rc(12'h200, 32'h0, `SCG2_RESP_SLVERR);
        wc(`SCG2_SLEEP_GATE_OFS, 32'h40000055, `SCG2_RESP_OKAY);
        wc(`SCG2_DSLEEP_GATE_OFS, 32'h1000002a, `SCG2_RESP_OKAY);
        mode(`SCG2_MODE_SLEEP, 9'h00f);
        wc(`SCG2_CTRL_OFS, 32'h1, `SCG2_RESP_OKAY);
        rc(`SCG2_CTRL_OFS, 32'h1, `SCG2_RESP_OKAY);
        mode(`SCG2_MODE_SLEEP, 9'h155);
        mode(`SCG2_MODE_DSLEEP, 9'h0aa);
        mode(2'h3, 9'h00f);
        mode(`SCG2_MODE_RUN, 9'h00f);
        rc(`SCG2_STATUS_OFS, 32'h0000000f, `SCG2_RESP_OKAY);
        probe(9'h010, 9'h000, 9'h010);
        probe(9'h000, 9'h001, 9'h000);
        wc(`SCG2_RUN_GATE_OFS, 32'he, `SCG2_RESP_OKAY);
        probe(9'h000, 9'h001, 9'h001);
        rc(`SCG2_IRQ_STAT_OFS, 32'h3, `SCG2_RESP_OKAY);
        check("irq", irq_o, 32'h0);
        wc(`SCG2_IRQ_MASK_OFS, 32'h3, `SCG2_RESP_OKAY);
        check("irq", irq_o, 32'h1);
        wc(`SCG2_IRQ_STAT_OFS, 32'h3, `SCG2_RESP_OKAY);
        check("irq", irq_o, 32'h0);
        rc(`SCG2_IRQ_STAT_OFS, 32'h0, `SCG2_RESP_OKAY);
        @(posedge mclk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        rc(`SCG2_SLEEP_GATE_OFS, 32'h0, `SCG2_RESP_OKAY);
        check("clk_en", unit_clk_en_o, 32'h0);
        close_out;
    end
endmodule
`default_nettype wire
